// file: common/cgc_pkg.sv
/*
 * Package for the counter gate control block: constants and carrier types.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package cgc_pkg;
    // ============================================================
    // Selector encodings and synchroniser reset value
    // ============================================================
    localparam logic [1:0] CGC_SRC_PIN      = 2'h0; // Gate from pin
    localparam logic [1:0] CGC_SRC_OVF8     = 2'h1; // 8-bit timer overflow
    localparam logic [1:0] CGC_SRC_OVFPER   = 2'h2; // Period timer overflow
    localparam logic [1:0] CGC_SRC_WDOG     = 2'h3; // Watchdog overflow
    localparam logic [1:0] CGC_CLK_CAPOSC   = 2'h3; // Cap-sense oscillator clock
    localparam logic [1:0] CGC_SYNC_RESET   = 2'h0; // Synchroniser reset value
    // ============================================================
    // Carrier types
    // ============================================================
    typedef struct packed {
        logic       counter_on;
        logic       gate_enable;
        logic       gate_polarity;
        logic       gate_toggle_enable;
        logic       gate_single_pulse_enable;
        logic [1:0] gate_source_select;
        logic [1:0] counter_clock_select;
        logic       gate_event_irq_enable;
        logic       watchdog_config_enable;
    } cgc_ctrl_t;
    typedef struct packed {
        logic pin;
        logic ovf8;
        logic ovfper;
        logic wdog;
    } cgc_src_t;
    // Single-pulse capture states, Gray from IDLE through ARMED to RUN
    typedef enum logic [1:0] {
        CGC_SP_IDLE  = 2'b00,
        CGC_SP_ARMED = 2'b01,
        CGC_SP_RUN   = 2'b11
    } cgc_sp_t;
endpackage

// file: core/cgc_gate_ctrl.sv
/*
 * Counter gate control: qualifies run/stop of a 16-bit counter, holds the
 * toggle flip-flop, single-pulse arm, gate level status and event flag.
 * Assumes gate sources are asynchronous and software bits are in-domain.
 */
`timescale 1ns/100ps
`default_nettype none
module cgc_gate_ctrl
    import cgc_pkg::*;
(
    // Clock and reset
    input  wire logic      ref_clk,
    input  wire logic      reset,
    input  wire logic      clk_en,
    // Software control
    input  wire cgc_ctrl_t ctrl,
    input  wire logic      arm_set,
    input  wire logic      flag_clear,
    // Gate sources
    input  wire cgc_src_t  src,
    // Status and control outputs
    output logic           gate_pulse_arm,
    output logic           gate_level_value,
    output logic           gate_event_flag,
    output logic           gate_irq,
    output logic           count_enable,
    output logic           cap_osc_clock_sel,
    output logic           wdog_osc_run,
    output logic           wdog_reset_allowed
);
    // ============================================================
    // Source selection and synchroniser
    // ============================================================
    logic       src_raw;      // Selected raw gate source
    logic [1:0] sync_q;       // First two synchroniser stages
    logic       sync3_q;      // Third stage
    logic       gate_q;       // Filtered gate level
    logic       gate_rise;    // Incrementing edge of source
    logic       toggle_q;     // Toggle flip-flop
    logic       level_d;      // Gate control value before arm qualifier
    logic       level_q;      // Registered gate control value
    cgc_sp_t    sp_q;         // Single-pulse state

    // Multiplex the gate sources
    always_comb begin
        case (ctrl.gate_source_select)
            CGC_SRC_PIN:    src_raw = src.pin;
            CGC_SRC_OVF8:   src_raw = src.ovf8;
            CGC_SRC_OVFPER: src_raw = src.ovfper;
            CGC_SRC_WDOG:   src_raw = src.wdog;
            default:        src_raw = src.pin;
        endcase
    end

    // Three-stage synchroniser, change accepted when stages two and three agree
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_q  <= CGC_SYNC_RESET;
            sync3_q <= 1'b0;
            gate_q  <= 1'b0;
        end else if (clk_en) begin
            sync_q  <= {sync_q[0], src_raw ^ ctrl.gate_polarity};
            sync3_q <= sync_q[1];
            if (sync_q[1] == sync3_q) begin
                gate_q <= sync3_q;
            end
        end
    end
    assign gate_rise = (sync_q[1] == sync3_q) && sync3_q && !gate_q;

    // ============================================================
    // Toggle flip-flop
    // ============================================================
    // Inverts on each rising edge, held clear while toggle mode is off
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            toggle_q <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl.gate_toggle_enable) begin
                toggle_q <= 1'b0;
            end else if (gate_rise) begin
                toggle_q <= !toggle_q;
            end
        end
    end

    // Gate value seen by single-pulse and counter; toggle feeds pulse logic
    assign level_d = ctrl.gate_toggle_enable ? toggle_q : gate_q;

    // ============================================================
    // Single-pulse capture
    // ============================================================
    logic lvl_prev_q;   // Previous level for edge detection
    logic lvl_rise;     // Leading edge of level
    logic lvl_fall;     // Trailing edge of level
    assign lvl_rise = level_d && !lvl_prev_q;
    assign lvl_fall = !level_d && lvl_prev_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lvl_prev_q <= 1'b0;
        end else if (clk_en) begin
            lvl_prev_q <= level_d;
        end
    end

    // Arm, run on leading edge, auto-disarm on trailing edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sp_q <= CGC_SP_IDLE;
        end else if (clk_en) begin
            if (!ctrl.gate_single_pulse_enable) begin
                sp_q <= CGC_SP_IDLE;
            end else begin
                case (sp_q)
                    CGC_SP_IDLE: begin
                        if (arm_set) begin
                            sp_q <= CGC_SP_ARMED;
                        end
                    end
                    CGC_SP_ARMED: begin
                        if (lvl_rise) begin
                            sp_q <= CGC_SP_RUN;
                        end
                    end
                    CGC_SP_RUN: begin
                        if (lvl_fall) begin
                            sp_q <= CGC_SP_IDLE;
                        end
                    end
                    default: sp_q <= CGC_SP_IDLE;
                endcase
            end
        end
    end

    // ============================================================
    // Status, event flag and counter qualification
    // ============================================================
    // Gate control value; live regardless of gate_enable
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            level_q <= 1'b0;
        end else if (clk_en) begin
            if (ctrl.gate_single_pulse_enable) begin
                level_q <= level_d && (sp_q == CGC_SP_RUN || lvl_rise && sp_q == CGC_SP_ARMED);
            end else begin
                level_q <= level_d;
            end
        end
    end

    // Outputs straight from flops
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gate_level_value   <= 1'b0;
            gate_pulse_arm     <= 1'b0;
            count_enable       <= 1'b0;
            cap_osc_clock_sel  <= 1'b0;
            wdog_osc_run       <= 1'b0;
            wdog_reset_allowed <= 1'b0;
        end else if (clk_en) begin
            gate_level_value  <= level_q;
            gate_pulse_arm    <= (sp_q != CGC_SP_IDLE);
            // Off, free running, or gated
            count_enable      <= ctrl.counter_on &&
                                 (!ctrl.gate_enable || level_q);
            cap_osc_clock_sel <= (ctrl.counter_clock_select == CGC_CLK_CAPOSC);
            wdog_osc_run      <= ctrl.watchdog_config_enable ||
                                 (ctrl.gate_enable &&
                                  ctrl.gate_source_select == CGC_SRC_WDOG);
            wdog_reset_allowed <= ctrl.watchdog_config_enable;
        end
    end

    // Event flag set on falling gate value; set wins over clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gate_event_flag <= 1'b0;
            gate_irq        <= 1'b0;
        end else if (clk_en) begin
            if (gate_level_value && !level_q) begin
                gate_event_flag <= 1'b1;
            end else if (flag_clear) begin
                gate_event_flag <= 1'b0;
            end
            gate_irq <= gate_event_flag && ctrl.gate_event_irq_enable;
        end
    end

    // ============================================================
    // Assertions
    // ============================================================
    toggle_held_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && !ctrl.gate_toggle_enable |=> !toggle_q)
        else $error("toggle flop not held clear");
    toggle_flip_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && ctrl.gate_toggle_enable && gate_rise |=> toggle_q != $past(toggle_q))
        else $error("toggle flop did not invert");
    arm_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && !ctrl.gate_single_pulse_enable ##1 clk_en |=> !gate_pulse_arm)
        else $error("arm not cleared with single-pulse off");
    disarm_edge_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && ctrl.gate_single_pulse_enable && sp_q == CGC_SP_RUN && lvl_fall
        |=> sp_q == CGC_SP_IDLE)
        else $error("no disarm on trailing edge");
    arm_start_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && ctrl.gate_single_pulse_enable && sp_q == CGC_SP_ARMED && lvl_rise
        |=> sp_q == CGC_SP_RUN)
        else $error("armed capture did not start");
    counter_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && !ctrl.counter_on |=> !count_enable)
        else $error("counter runs while off");
    counter_free_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && ctrl.counter_on && !ctrl.gate_enable |=> count_enable)
        else $error("counter not free running");
    event_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(gate_level_value) |-> gate_event_flag)
        else $error("event flag missed falling gate");
    cap_clock_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && ctrl.counter_clock_select == CGC_CLK_CAPOSC |=> cap_osc_clock_sel)
        else $error("cap oscillator clock not selected");
    wdog_run_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && ctrl.gate_enable && ctrl.gate_source_select == CGC_SRC_WDOG
        |=> wdog_osc_run)
        else $error("watchdog oscillator not running for gate");
endmodule
`default_nettype wire

// file: test/cgc_src_model.sv
/*
 * Gate source model: drives the four asynchronous gate sources.
 * Assumes the bench calls drive() and wires sel to the source selector.
 */
`timescale 1ns/100ps
`default_nettype none
module cgc_src_model
    import cgc_pkg::*;
(
    // Clock and selection
    input  wire logic       ref_clk,
    input  wire logic [1:0] sel,
    // Sources towards the block
    output cgc_src_t        src
);
    // ============================================================
    // Source levels
    // ============================================================
    integer     seed = 32'he18b3a57; // Fixed seed for wandering sources
    logic       lvl  = 1'b0;         // Level of the selected source
    logic [3:0] v;                   // Next source vector

    // Unselected sources wander, off the clock edge, like async flags
    always @(posedge ref_clk) begin
        #7;
        v = 4'($random(seed));
        v[3 - sel] = lvl;
        src <= cgc_src_t'(v);
    end

    // One high pulse of the selected source, then a low gap
    task automatic drive(input int hi, input int lo);
        @(posedge ref_clk) lvl = 1'b1;
        repeat (hi) @(posedge ref_clk);
        lvl = 1'b0;
        repeat (lo) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// file: test/test_counter_gate_control.sv
/*
 * Self-checking bench for the gate control block.
 * Assumes the source model drives src; clk_en is high but for one freeze.
 */
`timescale 1ns/100ps
`default_nettype none
module test_counter_gate_control
    import cgc_pkg::*;
();
    // ============================================================
    // Signals
    // ============================================================
    logic       ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic       arm_set = 1'b0, flag_clear = 1'b0;
    cgc_ctrl_t  ctrl    = '0;  // Software control bits
    cgc_src_t   src;           // Gate sources
    logic       gate_pulse_arm, gate_level_value, gate_event_flag, gate_irq;
    logic       count_enable, cap_osc_clock_sel, wdog_osc_run, wdog_reset_allowed;
    int         n_mismatch = 0, n_tests = 0;
    logic [1:0] exp_q[$];      // Expected {level, count_enable} per change
    logic       last_lvl = 1'b0;

    always #10 ref_clk = ~ref_clk;

    cgc_src_model src_u (.ref_clk(ref_clk), .sel(ctrl.gate_source_select), .src(src));

    cgc_gate_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .ctrl(ctrl),
        .arm_set(arm_set), .flag_clear(flag_clear), .src(src),
        .gate_pulse_arm(gate_pulse_arm), .gate_level_value(gate_level_value),
        .gate_event_flag(gate_event_flag), .gate_irq(gate_irq),
        .count_enable(count_enable), .cap_osc_clock_sel(cap_osc_clock_sel),
        .wdog_osc_run(wdog_osc_run), .wdog_reset_allowed(wdog_reset_allowed));

    // ============================================================
    // Checking
    // ============================================================
    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        n_tests++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // Each gate level change takes the oldest note off the queue
    always @(posedge ref_clk) begin
        if (!reset && gate_level_value !== last_lvl) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("BAD %0t unexpected gate level change", $time);
            end else begin
                check({gate_level_value, count_enable}, exp_q.pop_front());
            end
        end
        last_lvl <= gate_level_value;
    end

    task automatic print_verdict();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end

    // ============================================================
    // Stimulus helpers
    // ============================================================
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Note n expected changes, then one source pulse
    task automatic pulse(input int n, input logic [3:0] e);
        if (n > 0) exp_q.push_back(e[3:2]);
        if (n > 1) exp_q.push_back(e[1:0]);
        src_u.drive(8, 12);
    endtask

    // Flag and request after a fall, then software clear
    task automatic flag_chk();
        check(gate_event_flag, 1'b1);
        check(gate_irq, ctrl.gate_event_irq_enable);
        @(posedge ref_clk) flag_clear <= 1'b1;
        @(posedge ref_clk) flag_clear <= 1'b0;
        tick(3);
        check({gate_event_flag, gate_irq}, 2'b00);
    endtask

    task automatic arm();
        @(posedge ref_clk) arm_set <= 1'b1;
        @(posedge ref_clk) arm_set <= 1'b0;
        tick(2);
    endtask

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        tick(3);
        reset <= 1'b0;
        tick(2);
        pulse(2, 4'b1000);
        flag_chk();
        ctrl.counter_on <= 1'b1;
        ctrl.gate_event_irq_enable <= 1'b1;
        pulse(2, 4'b1101);
        flag_chk();
        exp_q.push_back(2'b11);
        ctrl.gate_enable <= 1'b1;
        ctrl.gate_polarity <= 1'b1;
        tick(10);
        pulse(2, 4'b0011);
        flag_chk();
        exp_q.push_back(2'b00);
        ctrl.gate_polarity <= 1'b0;
        tick(10);
        flag_chk();
        for (int s = 0; s < 4; s++) begin
            ctrl.gate_source_select <= 2'(s);
            ctrl.counter_clock_select <= 2'(s);
            tick(4);
            check(cap_osc_clock_sel, 4'(s == 3));
            check({wdog_osc_run, wdog_reset_allowed}, {s == 3, 1'b0});
            pulse(2, 4'b1100);
            flag_chk();
        end
        ctrl.watchdog_config_enable <= 1'b1;
        tick(4);
        check({wdog_osc_run, wdog_reset_allowed}, 2'b11);
        ctrl.gate_source_select <= CGC_SRC_OVF8;
        ctrl.gate_toggle_enable <= 1'b1;
        tick(4);
        pulse(1, 4'b1100);
        pulse(1, 4'b0000);
        flag_chk();
        pulse(1, 4'b1100);
        exp_q.push_back(2'b00);
        ctrl.gate_toggle_enable <= 1'b0;
        tick(10);
        // Frozen block must ignore a clear while the enable is low
        clk_en <= 1'b0;
        @(posedge ref_clk) flag_clear <= 1'b1;
        @(posedge ref_clk) flag_clear <= 1'b0;
        tick(1);
        check(gate_event_flag, 1'b1);
        clk_en <= 1'b1;
        flag_chk();
        ctrl.gate_single_pulse_enable <= 1'b1;
        tick(2);
        arm();
        check(gate_pulse_arm, 1'b1);
        pulse(2, 4'b1100);
        check(gate_pulse_arm, 1'b0);
        pulse(0, 4'b0000);
        ctrl.gate_toggle_enable <= 1'b1;
        arm();
        pulse(1, 4'b1100);
        check(gate_pulse_arm, 1'b1);
        pulse(1, 4'b0000);
        check(gate_pulse_arm, 1'b0);
        flag_chk();
        arm();
        ctrl.gate_single_pulse_enable <= 1'b0;
        tick(3);
        check(gate_pulse_arm, 1'b0);
        arm();
        check(gate_pulse_arm, 1'b0);
        tick(10);
        check(4'(exp_q.size()), 4'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
